// File: rtl/spci_pkg.sv
`default_nettype none
package spci_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA = 8'h21;
  localparam logic [7:0] IDX_CTRL = 8'h22;
  localparam logic [7:0] IDX_STAT = 8'h23;
  localparam logic [7:0] ADDR_DATA = {IDX_DATA[5:0], 2'h0};
  localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'h0};
  localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'h0};
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam int CB_IRQ_EN = 7;
  localparam int CB_PIN_EN = 6;
  localparam int CB_RATE_DIV = 5;
  localparam int CB_MASTER = 4;
  localparam int CB_IDLE = 3;
  localparam int CB_CAPT = 2;
  localparam int SB_DONE = 7;
  localparam int SB_WRITE_COLLISION_FLAG = 6;
  localparam int SB_FAULT = 4;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;
  localparam logic [1:0] SEL_STAT = 2'h3;
  typedef enum logic [1:0] {SPCI_IDLE = 2'b01, SPCI_RUN = 2'b10} spci_state_t;

  function automatic logic [1:0] spci_sel(input logic [7:0] addr);
    case (addr)
      ADDR_DATA: spci_sel = SEL_DATA;
      ADDR_CTRL: spci_sel = SEL_CTRL;
      ADDR_STAT: spci_sel = SEL_STAT;
      default: spci_sel = SEL_NONE;
    endcase
  endfunction

  // half period of sck in system clocks, indexed by {rate div, rate bits}
  function automatic logic [6:0] spci_half(input logic [2:0] code);
    case (code)
      3'h4: spci_half = 7'h02;
      3'h0: spci_half = 7'h04;
      3'h1: spci_half = 7'h08;
      3'h6: spci_half = 7'h10;
      3'h2: spci_half = 7'h20;
      3'h3: spci_half = 7'h40;
      default: spci_half = 7'h02;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: rtl/spci_sync.sv
`default_nettype none
module spci_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] ff1_reg, ff2_reg, ff3_reg, level_reg, level_next;

  // a change counts only once the second and third stages agree
  always_comb begin
    level_next = ((ff2_reg ~^ ff3_reg) & ff3_reg) | ((ff2_reg ^ ff3_reg) & level_reg);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ff1_reg <= RST;
      ff2_reg <= RST;
      ff3_reg <= RST;
      level_reg <= RST;
    end else if (clk_en) begin
      ff1_reg <= pin;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule
`default_nettype wire

// File: rtl/spci_clkdiv.sv
`default_nettype none
module spci_clkdiv (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [6:0] half,
  output logic tick
);
  logic [6:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    cnt_next = 7'h00;
    tick_next = 1'b0;
    if (run) begin
      if (cnt_reg == half - 7'h01) begin
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule
`default_nettype wire

// File: rtl/spci_top.sv
`default_nettype none
module spci_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_irq_mask,
  output logic irq_req,
  output logic wake_req,
  input wire logic ss_b_pin,
  input wire logic sck_pin_i,
  output logic sck_pin_o,
  output logic sck_pin_oe,
  input wire logic mosi_pin_i,
  output logic mosi_pin_o,
  output logic mosi_pin_oe,
  input wire logic miso_pin_i,
  output logic miso_pin_o,
  output logic miso_pin_oe,
  input wire logic [2:0] port_o,
  input wire logic [2:0] port_oe
);
  ////////////////////////////////////////////////////////////////////////
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0] waddr_reg, waddr_next, wdat_reg, wdat_next;
  logic wstb_reg, wstb_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_go, wr_en, rd_go;
  logic [1:0] wsel, rsel;

  logic [7:0] ctrl_reg, ctrl_next, tx_reg, tx_next, rx_reg, rx_next, buf_reg, buf_next;
  logic done_reg, done_next, write_collision_flag_reg, write_collision_flag_next, fault_reg, fault_next;
  logic arm_done_reg, arm_done_next, arm_write_collision_flag_reg, arm_write_collision_flag_next;
  logic arm_fault_reg, arm_fault_next;
  spci_pkg::spci_state_t st_reg, st_next;
  logic [3:0] edge_reg, edge_next;
  logic sck_ph_reg, sck_ph_next, sck_prev_reg, ss_prev_reg;
  logic irq_reg, irq_next, wake_reg, wake_next;
  logic [2:0] pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
  logic ss_s, sck_s, mosi_s, miso_s, tick, master, pin_en, capt;
  logic busy, ev, din, data_acc, stat_acc, irq_src;
  logic [7:0] stat_val;

  ////////////////////////////////////////////////////////////////////////
  spci_sync #(.W(4), .RST(4'hF)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin({ss_b_pin, sck_pin_i, mosi_pin_i, miso_pin_i}),
    .level({ss_s, sck_s, mosi_s, miso_s})
  );

  // rate bits only reach the divider, which runs only for a master transfer
  spci_clkdiv u_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .run(st_reg == spci_pkg::SPCI_RUN && master),
    .half(spci_pkg::spci_half({ctrl_reg[spci_pkg::CB_RATE_DIV], ctrl_reg[1:0]})),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave: address and data are latched independently, response after both
  assign wsel = spci_pkg::spci_sel(waddr_reg);
  assign rsel = spci_pkg::spci_sel(s_axi_araddr);
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_en = wr_go && wstb_reg;
  assign rd_go = s_axi_arvalid && arready_reg;
  assign stat_val = {done_reg, write_collision_flag_reg, 1'b0, fault_reg, 4'h0};

  always_comb begin
    awready_next = awready_reg;
    wready_next = wready_reg;
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    waddr_next = waddr_reg;
    wdat_next = wdat_reg;
    wstb_next = wstb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awready_next = 1'b0;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wready_next = 1'b0;
      wdat_next = s_axi_wdata[7:0];
      wstb_next = s_axi_wstrb[0];
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wsel == spci_pkg::SEL_NONE) ? spci_pkg::RESP_SLVERR : spci_pkg::RESP_OKAY;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    if (rd_go) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = (rsel == spci_pkg::SEL_NONE) ? spci_pkg::RESP_SLVERR : spci_pkg::RESP_OKAY;
      case (rsel)
        spci_pkg::SEL_DATA: rdata_next = buf_reg;
        spci_pkg::SEL_CTRL: rdata_next = ctrl_reg;
        spci_pkg::SEL_STAT: rdata_next = stat_val;
        default: rdata_next = 8'h00;
      endcase
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdat_reg <= 8'h00;
      wstb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      waddr_reg <= waddr_next;
      wdat_reg <= wdat_next;
      wstb_reg <= wstb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign master = ctrl_reg[spci_pkg::CB_MASTER];
  assign pin_en = ctrl_reg[spci_pkg::CB_PIN_EN];
  assign capt = ctrl_reg[spci_pkg::CB_CAPT];
  assign din = master ? miso_s : mosi_s;
  // a selected slave with first-edge capture freezes its data from select onward
  assign busy = st_reg == spci_pkg::SPCI_RUN || (!master && pin_en && !ss_s && !capt);
  assign ev = st_reg == spci_pkg::SPCI_RUN && (master ? tick : sck_s != sck_prev_reg);
  assign data_acc = (wr_go && wsel == spci_pkg::SEL_DATA) || (rd_go && rsel == spci_pkg::SEL_DATA);
  assign stat_acc = (wr_go && wsel == spci_pkg::SEL_STAT) || (rd_go && rsel == spci_pkg::SEL_STAT);
  assign irq_src = ctrl_reg[spci_pkg::CB_IRQ_EN] && (done_reg || fault_reg);

  always_comb begin
    ctrl_next = ctrl_reg;
    done_next = done_reg;
    write_collision_flag_next = write_collision_flag_reg;
    fault_next = fault_reg;
    arm_done_next = arm_done_reg;
    arm_write_collision_flag_next = arm_write_collision_flag_reg;
    arm_fault_next = arm_fault_reg;
    st_next = st_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    buf_next = buf_reg;
    edge_next = edge_reg;
    sck_ph_next = sck_ph_reg;
    if (wr_en && wsel == spci_pkg::SEL_CTRL) begin
      ctrl_next = wdat_reg;
      if (fault_reg && !arm_fault_reg) begin
        ctrl_next[spci_pkg::CB_PIN_EN] = pin_en && wdat_reg[spci_pkg::CB_PIN_EN];
        ctrl_next[spci_pkg::CB_MASTER] = master && wdat_reg[spci_pkg::CB_MASTER];
      end
      if (arm_fault_reg) begin
        fault_next = 1'b0;
        arm_fault_next = 1'b0;
      end
    end
    // clears come first so a collision in the same cycle still sets the flag
    if (data_acc) begin
      if (arm_done_reg) begin
        done_next = 1'b0;
      end
      if (arm_write_collision_flag_reg) begin
        write_collision_flag_next = 1'b0;
      end
      arm_done_next = 1'b0;
      arm_write_collision_flag_next = 1'b0;
    end
    if (wr_en && wsel == spci_pkg::SEL_DATA) begin
      if (busy) begin
        write_collision_flag_next = 1'b1;
      end else if (!done_reg || arm_done_reg) begin
        tx_next = wdat_reg;
        if (master && pin_en) begin
          st_next = spci_pkg::SPCI_RUN;
          edge_next = 4'h0;
        end
      end
    end
    if (stat_acc) begin
      arm_done_next = done_reg;
      arm_write_collision_flag_next = write_collision_flag_reg;
      arm_fault_next = fault_reg;
    end
    // slave: a new byte begins on select falling, or back to back with second-edge capture
    if (!master && pin_en && !ss_s && st_reg == spci_pkg::SPCI_IDLE && (ss_prev_reg || capt)) begin
      st_next = spci_pkg::SPCI_RUN;
      edge_next = 4'h0;
    end
    if (ev) begin
      if (edge_reg[0] == capt) begin
        rx_next = {rx_reg[6:0], din};
      end else if (!(capt && edge_reg == 4'h0)) begin
        tx_next = {tx_reg[6:0], 1'b0};
      end
      sck_ph_next = master ? !sck_ph_reg : 1'b0;
      edge_next = edge_reg + 4'h1;
      if (edge_reg == spci_pkg::LAST_EDGE) begin
        st_next = spci_pkg::SPCI_IDLE;
        done_next = 1'b1;
        buf_next = rx_next;
      end
    end
    if (!master && (ss_s || !pin_en) && st_reg == spci_pkg::SPCI_RUN) begin
      st_next = spci_pkg::SPCI_IDLE;
      sck_ph_next = 1'b0;
    end
    // hardware fault wins over any software write of the same cycle
    if (master && !ss_s) begin
      fault_next = 1'b1;
      ctrl_next[spci_pkg::CB_PIN_EN] = 1'b0;
      ctrl_next[spci_pkg::CB_MASTER] = 1'b0;
      st_next = spci_pkg::SPCI_IDLE;
      sck_ph_next = 1'b0;
    end
  end

  // pins and request leave through flops; the port owns the pins while disabled
  always_comb begin
    irq_next = irq_src && !cpu_irq_mask;
    wake_next = irq_src;
    pin_o_next = port_o;
    pin_oe_next = port_oe;
    if (pin_en) begin
      pin_o_next = {tx_reg[7], tx_reg[7], ctrl_reg[spci_pkg::CB_IDLE] ^ sck_ph_reg};
      pin_oe_next = {!master && !ss_s, master, master};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_reg <= spci_pkg::CTRL_RST;
      {done_reg, write_collision_flag_reg, fault_reg} <= 3'h0;
      {arm_done_reg, arm_write_collision_flag_reg, arm_fault_reg} <= 3'h0;
      st_reg <= spci_pkg::SPCI_IDLE;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      buf_reg <= 8'h00;
      edge_reg <= 4'h0;
      sck_ph_reg <= 1'b0;
      sck_prev_reg <= 1'b1;
      ss_prev_reg <= 1'b1;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      pin_o_reg <= 3'h0;
      pin_oe_reg <= 3'h0;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      {done_reg, write_collision_flag_reg, fault_reg} <= {done_next, write_collision_flag_next, fault_next};
      {arm_done_reg, arm_write_collision_flag_reg, arm_fault_reg} <= {arm_done_next, arm_write_collision_flag_next, arm_fault_next};
      st_reg <= st_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      buf_reg <= buf_next;
      edge_reg <= edge_next;
      sck_ph_reg <= sck_ph_next;
      sck_prev_reg <= sck_s;
      ss_prev_reg <= ss_s;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
      pin_o_reg <= pin_o_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};
  assign irq_req = irq_reg;
  assign wake_req = wake_reg;
  assign {miso_pin_o, mosi_pin_o, sck_pin_o} = pin_o_reg;
  assign {miso_pin_oe, mosi_pin_oe, sck_pin_oe} = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_irq_pass: assert property (clk_en && irq_src && !cpu_irq_mask |=> irq_req)
    else $error("enabled request not passed");
  a_irq_block: assert property (clk_en && !ctrl_reg[spci_pkg::CB_IRQ_EN] |=> !irq_req && !wake_req)
    else $error("request without enable");
  a_fault_drop: assert property (clk_en && master && !ss_s |=> fault_reg && !pin_en && !master)
    else $error("fault did not drop pin enable and master");
  a_port_pins: assert property (clk_en && !pin_en |=> sck_pin_o == $past(port_o[0])
    && sck_pin_oe == $past(port_oe[0]))
    else $error("port does not own pins");
  a_done_hold: assert property (clk_en && wr_en && wsel == spci_pkg::SEL_DATA && done_reg
    && !arm_done_reg && st_reg == spci_pkg::SPCI_IDLE |=> tx_reg == $past(tx_reg))
    else $error("data write taken while done");
  a_write_collision_flag_set: assert property (clk_en && wr_en && wsel == spci_pkg::SEL_DATA && busy |=> write_collision_flag_reg)
    else $error("collision not flagged");
  a_master_start: assert property (clk_en && st_reg == spci_pkg::SPCI_IDLE && master
    ##1 st_reg == spci_pkg::SPCI_RUN |-> $past(wr_en && wsel == spci_pkg::SEL_DATA))
    else $error("master began without data write");
  a_done_clear: assert property (clk_en && arm_done_reg && data_acc && !ev |=> !done_reg)
    else $error("done flag not cleared");
  a_fault_guard: assert property (clk_en && fault_reg && !arm_fault_reg && !pin_en
    && !(master && !ss_s) |=> !pin_en)
    else $error("pin enable set during fault");
  a_sck_idle: assert property (clk_en && st_reg == spci_pkg::SPCI_IDLE && pin_en && master
    ##1 clk_en && pin_en && master |=> sck_pin_o == $past(ctrl_reg[spci_pkg::CB_IDLE]))
    else $error("sck not at idle level");

  c_master_byte: cover property (st_reg == spci_pkg::SPCI_RUN && master ##[1:300] done_reg);
  c_fault: cover property (fault_reg && irq_req);
  c_write_collision_flag: cover property (write_collision_flag_reg ##[1:50] !write_collision_flag_reg);
  c_slave_byte: cover property (st_reg == spci_pkg::SPCI_RUN && !master ##[1:300] done_reg);
endmodule
`default_nettype wire

// File: tb/spci_partner.sv
`default_nettype none
module spci_partner (
  input wire logic clk_sys,
  input wire logic sel_b,
  input wire logic sck,
  input wire logic mosi,
  input wire logic capt,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q = 1'b0;
  logic sel_q = 1'b1;
  logic last = 1'b0;
  int edges = 0;
  int idx;
  ////////////////////////////////////////////////////////////
  // sck is watched on the system clock, so each half period must last two clocks or more
  always @(posedge clk_sys) begin
    sck_q <= sck;
    sel_q <= sel_b;
    last <= miso;
    if (sel_q && !sel_b) begin
      edges <= 0;
    end else if (!sel_b && sck !== sck_q) begin
      edges <= edges + 1;
      if (edges[0] == capt) begin
        rx_byte <= {rx_byte[6:0], mosi};
      end
    end
  end
  always_comb idx = capt ? ((edges == 0) ? 0 : (edges - 1) / 2) : edges / 2;
  // a released line toggles every clock so a stale bit never passes for data
  assign miso = (!sel_b && idx < 8) ? tx_byte[7 - idx] : ~last;
endmodule
`default_nettype wire

// File: tb/test_spi_control_status_interrupts.sv
`default_nettype none
module test_spi_control_status_interrupts;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic cpu_irq_mask = 1'b0;
  logic ss_b_pin = 1'b1;
  logic irq_req, wake_req, sck_pin_o, sck_pin_oe, mosi_pin_o, mosi_pin_oe, miso_pin_o, miso_pin_oe;
  logic [2:0] port_o = 3'h5;
  logic [2:0] port_oe = 3'h6;
  logic [7:0] ctrl = 8'h00;
  logic [7:0] v;
  logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  logic part_sel_b = 1'b1;
  logic sck_drv = 1'b0;
  logic part_miso, s;
  logic [7:0] part_rx;
  int fails = 0;
  int comparisons = 0;
  int n;
  wire logic sck_pin_i = sck_pin_oe ? sck_pin_o : sck_drv;
  // as a slave the block hears its own miso back, so the byte it sends is the byte it gets
  wire logic mosi_pin_i = mosi_pin_oe ? mosi_pin_o : miso_pin_o;
  wire logic miso_pin_i = miso_pin_oe ? miso_pin_o : part_miso;

  spci_top spci_top_inst (.clk_sys, .rst_b, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_irq_mask,
    .irq_req, .wake_req, .ss_b_pin, .sck_pin_i, .sck_pin_o, .sck_pin_oe, .mosi_pin_i, .mosi_pin_o, .mosi_pin_oe,
    .miso_pin_i, .miso_pin_o, .miso_pin_oe, .port_o, .port_oe);
  spci_partner spci_partner_inst (.clk_sys, .sel_b(part_sel_b), .sck(sck_pin_i), .mosi(mosi_pin_i),
    .capt(ctrl[2]), .tx_byte(8'h3C), .miso(part_miso), .rx_byte(part_rx));

  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // handshakes are judged at the falling edge, so releases land cleanly after the taking edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t, done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge clk_sys);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid & s_axi_bready;
      if (b_t) rsp = s_axi_bresp;
      @(posedge clk_sys);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
      done = b_t;
    end
    @(negedge clk_sys);
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic ar_t, r_t, done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge clk_sys);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t = s_axi_rvalid & s_axi_rready;
      if (r_t) rd = s_axi_rdata;
      if (r_t) rsp = s_axi_rresp;
      @(posedge clk_sys);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
      done = r_t;
    end
    @(negedge clk_sys);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    axi_read(a);
    check(what, rd, exp);
  endtask

  task automatic wait_wake();
    for (n = 0; n < 3000 && wake_req !== 1'b1; n++) @(negedge clk_sys);
  endtask

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge clk_sys);
    fails++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(spci_pkg::ADDR_CTRL, 32'h0, "control after reset");
    rchk(spci_pkg::ADDR_STAT, 32'h0, "status after reset");
    check("pins follow port", {miso_pin_o, mosi_pin_o, sck_pin_o}, port_o);
    check("port enables", {miso_pin_oe, mosi_pin_oe, sck_pin_oe}, port_oe);
    axi_write(spci_pkg::ADDR_STAT, 32'h0000_00FF);
    rchk(spci_pkg::ADDR_STAT, 32'h0, "status write ignored");
    axi_write(8'h00, 32'h0);
    check("unmapped write", rsp, spci_pkg::RESP_SLVERR);
    rchk(8'h00, 32'h0, "unmapped read data");
    check("unmapped read", rsp, spci_pkg::RESP_SLVERR);
    $display("test reset and map done");
    // every idle level and capture edge, at divide by 32
    for (int m = 0; m < 4; m++) begin
      v = 8'hF2 | {4'h0, 2'(m), 2'h0};
      ctrl <= v;
      axi_write(spci_pkg::ADDR_CTRL, {24'h0, v});
      rchk(spci_pkg::ADDR_CTRL, {24'h0, v}, "control readback");
      check("sck idle level", sck_pin_o, v[3]);
      check("master directions", {miso_pin_oe, mosi_pin_oe, sck_pin_oe}, 3'h3);
      @(posedge clk_sys);
      part_sel_b <= 1'b0;
      axi_write(spci_pkg::ADDR_DATA, 32'h0000_00A5);
      wait_wake();
      check("wake on done", wake_req, 1'b1);
      check("irq unmasked", irq_req, 1'b1);
      @(posedge clk_sys);
      cpu_irq_mask <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check("irq masked", irq_req, 1'b0);
      check("wake ignores mask", wake_req, 1'b1);
      @(posedge clk_sys);
      cpu_irq_mask <= 1'b0;
      axi_write(spci_pkg::ADDR_CTRL, {24'h0, v & 8'h7F});
      check("no wake without enable", wake_req, 1'b0);
      check("byte at far side", part_rx, 8'hA5);
      rchk(spci_pkg::ADDR_STAT, 32'h0000_0080, "done flag");
      rchk(spci_pkg::ADDR_DATA, 32'h0000_003C, "received byte");
      rchk(spci_pkg::ADDR_STAT, 32'h0, "done cleared");
      @(posedge clk_sys);
      part_sel_b <= 1'b1;
      $display("test mode %0d done", m);
    end
    for (int r = 0; r < 6; r++) begin
      v = {2'h3, codes[r][2], 3'h4, codes[r][1:0]};
      ctrl <= v;
      axi_write(spci_pkg::ADDR_CTRL, {24'h0, v});
      axi_write(spci_pkg::ADDR_DATA, 32'h0);
      s = sck_pin_o;
      for (n = 0; n < 300 && sck_pin_o === s; n++) @(negedge clk_sys);
      s = sck_pin_o;
      for (n = 0; n < 300 && sck_pin_o === s; n++) @(negedge clk_sys);
      check("sck half period", n, 2 << r);
      wait_wake();
      rchk(spci_pkg::ADDR_STAT, 32'h0000_0080, "done at rate");
      axi_read(spci_pkg::ADDR_DATA);
    end
    $display("test rates done");
    axi_write(spci_pkg::ADDR_CTRL, 32'h0000_00F2);
    axi_write(spci_pkg::ADDR_DATA, 32'h0000_0011);
    axi_write(spci_pkg::ADDR_DATA, 32'h0000_0022);
    wait_wake();
    axi_write(spci_pkg::ADDR_DATA, 32'h0000_0033);
    s = sck_pin_o;
    for (n = 0; n < 100 && sck_pin_o === s; n++) @(negedge clk_sys);
    check("write ignored while done", n, 100);
    rchk(spci_pkg::ADDR_STAT, 32'h0000_00C0, "collision flag");
    axi_read(spci_pkg::ADDR_DATA);
    rchk(spci_pkg::ADDR_STAT, 32'h0, "flags cleared");
    $display("test collision done");
    @(posedge clk_sys);
    ss_b_pin <= 1'b0;
    repeat (8) @(negedge clk_sys);
    check("fault request", irq_req, 1'b1);
    @(posedge clk_sys);
    ss_b_pin <= 1'b1;
    rchk(spci_pkg::ADDR_CTRL, 32'h0000_00A2, "fault drops enables");
    axi_write(spci_pkg::ADDR_CTRL, 32'h0000_00F2);
    rchk(spci_pkg::ADDR_CTRL, 32'h0000_00A2, "set refused in fault");
    rchk(spci_pkg::ADDR_STAT, 32'h0000_0010, "fault flag");
    axi_write(spci_pkg::ADDR_CTRL, 32'h0000_00F2);
    rchk(spci_pkg::ADDR_STAT, 32'h0, "fault cleared");
    rchk(spci_pkg::ADDR_CTRL, 32'h0000_00F2, "set in clearing");
    $display("test fault done");
    axi_write(spci_pkg::ADDR_CTRL, 32'h0000_0043);
    axi_write(spci_pkg::ADDR_DATA, 32'h0000_0096);
    @(posedge clk_sys);
    ss_b_pin <= 1'b0;
    repeat (8) @(negedge clk_sys);
    check("slave directions", {miso_pin_oe, mosi_pin_oe, sck_pin_oe}, 3'h4);
    axi_write(spci_pkg::ADDR_DATA, 32'h0000_0055);
    repeat (16) begin
      repeat (8) @(posedge clk_sys);
      sck_drv <= ~sck_drv;
    end
    repeat (10) @(negedge clk_sys);
    rchk(spci_pkg::ADDR_STAT, 32'h0000_00C0, "slave flags");
    rchk(spci_pkg::ADDR_DATA, 32'h0000_0096, "slave byte");
    @(posedge clk_sys);
    ss_b_pin <= 1'b1;
    $display("test slave done");
    summarize();
  end
endmodule
`default_nettype wire
